// [shared/spindle_defs.svh]
`ifndef SPINDLE_DEFS_SVH
`define SPINDLE_DEFS_SVH

// ----------------------------------------------------------------------
// Time base
// ----------------------------------------------------------------------
`define CLK_HZ              20000000

// ----------------------------------------------------------------------
// Timing figures and derived cycle counts
// ----------------------------------------------------------------------
`define START_WIND_TIME_S   9
`define START_WIND_CYCLES   (`START_WIND_TIME_S * `CLK_HZ)
`define TACH_GAP_TIME_US    10000
`define TACH_GAP_CYCLES     (`TACH_GAP_TIME_US * (`CLK_HZ / 1000000))
`define SEEN_WINDOW_TIME_MS 100
`define SEEN_WINDOW_CYCLES  (`SEEN_WINDOW_TIME_MS * (`CLK_HZ / 1000))
`define SETTLE_TIME_S       10
`define SETTLE_CYCLES       (`SETTLE_TIME_S * `CLK_HZ)

// ----------------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------------
`define TIMER_WIDTH         28
`define HALF_REVS_PER_REV   2

`endif

// [shared/spindle_pkg.sv]
`default_nettype none

package spindle_pkg;

   // -------------------------------------------------------------------
   // Motor sequencing states
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      MOTOR_STOPPED  = 2'b00,
      MOTOR_STARTING = 2'b01,
      MOTOR_RUNNING  = 2'b10,
      MOTOR_TRIPPED  = 2'b11
   } motor_state_type;

endpackage

`default_nettype wire

// [shared/timer_if.sv]
`default_nettype none

// ----------------------------------------------------------------------
// Control and status of one one-shot timer
// ----------------------------------------------------------------------
interface timer_if;
   logic restart;
   logic abort;
   logic running;
   logic fire;

   modport owner (output restart, output abort, input running, input fire);
   modport timer (input restart, input abort, output running, output fire);
endinterface

`default_nettype wire

// [design/interval_timer.sv]
`default_nettype none

// ----------------------------------------------------------------------
// One-shot down counter; fire pulses LIMIT edges after restart
// ----------------------------------------------------------------------
module interval_timer #(
   parameter int WIDTH = 28,
   parameter int LIMIT = 16
) (
   input  wire logic mclk,
   input  wire logic rstn,
   timer_if.timer    tif
);

   logic [WIDTH-1:0] count;

   // Restart beats expiry, so a pulse on the last cycle re-arms cleanly
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         count       <= '0;
         tif.running <= 1'b0;
         tif.fire    <= 1'b0;
      end else if (tif.restart) begin
         count       <= WIDTH'(LIMIT - 1);
         tif.running <= 1'b1;
         tif.fire    <= 1'b0;
      end else if (tif.abort) begin
         tif.running <= 1'b0;
         tif.fire    <= 1'b0;
      end else if (tif.running) begin
         if (count == '0) begin
            tif.running <= 1'b0;
            tif.fire    <= 1'b1;
         end else begin
            count    <= count - 1'b1;
            tif.fire <= 1'b0;
         end
      end else begin
         tif.fire <= 1'b0;
      end
   end

endmodule // interval_timer

`default_nettype wire

// [design/spindle_speed_interlock.sv]
// Operation
// - At start drive both windings; drop start winding after nine seconds.
// - Thermal switch open kills motor; no restart until manually reset.
// - Each tach pulse counts as half a revolution; two make one turn.
// - Gap timer restarts per pulse; rate ok once it cannot expire.
// - Carriage safety relay picked only and always while rate ok holds.
// - Start request passes only while the cover switch is closed.
// - Cover solenoid on only with power, no start, no tach pulses.
// - Drive operations held off until spindle rate ok is asserted.
// - Ten seconds after rate ok, settled asserts and loads heads unless voltage fault.
`include "spindle_defs.svh"
`default_nettype none

module spindle_speed_interlock
   import spindle_pkg::*;
#(
   parameter int START_CYCLES  = `START_WIND_CYCLES,
   parameter int GAP_CYCLES    = `TACH_GAP_CYCLES,
   parameter int SEEN_CYCLES   = `SEEN_WINDOW_CYCLES,
   parameter int SETTLE_CYCLES = `SETTLE_CYCLES,
   parameter int TIMER_WIDTH   = `TIMER_WIDTH
) (
   input  wire logic mclk,
   input  wire logic rstn,
   input  wire logic start_req,
   input  wire logic cover_closed,
   input  wire logic thermal_ok,
   input  wire logic thermal_reset,
   input  wire logic heads_loaded,
   input  wire logic tach_pulse,
   input  wire logic voltage_fault,
   input  wire logic dc_power_on,
   input  wire logic cover_lock_fitted,
   output logic      start_gated,
   output logic      start_winding,
   output logic      run_winding,
   output logic      motor_tripped,
   output logic      tach_seen,
   output logic      spindle_rate_ok,
   output logic      rate_ok_settled,
   output logic      carriage_relay,
   output logic      ops_enable,
   output logic      head_load,
   output logic      cover_solenoid
);

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   motor_state_type state;
   motor_state_type next_state;
   logic            tach_prev;
   logic            tach_edge;
   logic            half_rev;
   logic            rate_prev;
   logic            start_flop;
   logic            sol_flop;

   timer_if start_t ();
   timer_if gap_t ();
   timer_if seen_t ();
   timer_if settle_t ();

   // -------------------------------------------------------------------
   // Timers
   // -------------------------------------------------------------------
   interval_timer #(.WIDTH(TIMER_WIDTH), .LIMIT(START_CYCLES)) u_start (
      .mclk (mclk),
      .rstn (rstn),
      .tif  (start_t)
   );

   interval_timer #(.WIDTH(TIMER_WIDTH), .LIMIT(GAP_CYCLES)) u_gap (
      .mclk (mclk),
      .rstn (rstn),
      .tif  (gap_t)
   );

   interval_timer #(.WIDTH(TIMER_WIDTH), .LIMIT(SEEN_CYCLES)) u_seen (
      .mclk (mclk),
      .rstn (rstn),
      .tif  (seen_t)
   );

   interval_timer #(.WIDTH(TIMER_WIDTH), .LIMIT(SETTLE_CYCLES)) u_settle (
      .mclk (mclk),
      .rstn (rstn),
      .tif  (settle_t)
   );

   // -------------------------------------------------------------------
   // Start gating
   // -------------------------------------------------------------------
   // cover switch in series
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         start_flop <= 1'b0;
      end else begin
         start_flop <= start_req & cover_closed;
      end
   end
   assign start_gated = start_flop;

   // -------------------------------------------------------------------
   // Motor sequencer
   // -------------------------------------------------------------------
   // Run winding is held until heads are off the pack (a thermal trip drops it
   // at once), so a stop request never spins the pack down under flying heads
   always_comb begin
      next_state = state;
      case (state)
         MOTOR_STOPPED: begin
            if (start_flop)
               next_state = MOTOR_STARTING;
         end
         MOTOR_STARTING: begin
            if (!start_flop && !heads_loaded)
               next_state = MOTOR_STOPPED;
            else if (start_t.fire)
               next_state = MOTOR_RUNNING;
         end
         MOTOR_RUNNING: begin
            if (!start_flop && !heads_loaded)
               next_state = MOTOR_STOPPED;
         end
         MOTOR_TRIPPED: begin
            if (thermal_reset && thermal_ok)
               next_state = MOTOR_STOPPED;
         end
         default: next_state = MOTOR_STOPPED;
      endcase
      if (!thermal_ok)
         next_state = MOTOR_TRIPPED;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state <= MOTOR_STOPPED;
      end else begin
         state <= next_state;
      end
   end

   assign start_t.restart = (state == MOTOR_STOPPED) &&
                            (next_state == MOTOR_STARTING);
   assign start_t.abort   = (state != MOTOR_STARTING);

   assign start_winding = (state == MOTOR_STARTING);
   assign run_winding   = (state == MOTOR_STARTING) ||
                          (state == MOTOR_RUNNING);
   assign motor_tripped = (state == MOTOR_TRIPPED);

   // -------------------------------------------------------------------
   // Tachometer and speed sensing
   // -------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tach_prev <= 1'b0;
      end else begin
         tach_prev <= tach_pulse;
      end
   end
   assign tach_edge = tach_pulse & ~tach_prev;

   assign gap_t.restart  = tach_edge;
   assign gap_t.abort    = 1'b0;
   assign seen_t.restart = tach_edge;
   assign seen_t.abort   = 1'b0;
   assign tach_seen      = seen_t.running;

   // two short gaps make one turn
   // A pulse and an expiry in one cycle can meet: the expiry wins and clears both
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         half_rev        <= 1'b0;
         spindle_rate_ok <= 1'b0;
      end else if (gap_t.fire) begin
         half_rev        <= 1'b0;
         spindle_rate_ok <= 1'b0;
      end else if (tach_edge) begin
         if (!gap_t.running) begin
            half_rev <= 1'b0;
         end else if (half_rev) begin
            spindle_rate_ok <= 1'b1;
         end else begin
            half_rev <= 1'b1;
         end
      end
   end

   // -------------------------------------------------------------------
   // Settling delay and head load
   // -------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rate_prev <= 1'b0;
      end else begin
         rate_prev <= spindle_rate_ok;
      end
   end

   assign settle_t.restart = spindle_rate_ok & ~rate_prev;
   assign settle_t.abort   = ~spindle_rate_ok;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rate_ok_settled <= 1'b0;
      end else if (!spindle_rate_ok) begin
         rate_ok_settled <= 1'b0;
      end else if (settle_t.fire) begin
         rate_ok_settled <= 1'b1;
      end
   end

   assign head_load      = rate_ok_settled & ~voltage_fault;
   assign carriage_relay = spindle_rate_ok;
   assign ops_enable     = spindle_rate_ok;

   // -------------------------------------------------------------------
   // Cover lock solenoid
   // -------------------------------------------------------------------
   // release only when at rest
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sol_flop <= 1'b0;
      end else begin
         sol_flop <= cover_lock_fitted & dc_power_on &
                     ~start_flop & ~seen_t.running;
      end
   end
   assign cover_solenoid = sol_flop;

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   property p_start_drop;
      (state == MOTOR_STARTING) && start_t.fire && thermal_ok &&
      (start_flop || heads_loaded) |=> run_winding && !start_winding;
   endproperty
   a_start_drop: assert property (p_start_drop)
      else $error("start winding not dropped at timer expiry");

   property p_thermal_trip;
      !thermal_ok |=> motor_tripped && !run_winding;
   endproperty
   a_thermal_trip: assert property (p_thermal_trip)
      else $error("motor not tripped after thermal open");

   // Only a manual reset with the switch closed leaves the trip
   property p_thermal_hold;
      motor_tripped && !(thermal_reset && thermal_ok)
      |=> motor_tripped && !run_winding;
   endproperty
   a_thermal_hold: assert property (p_thermal_hold)
      else $error("motor not held off after thermal open");

   property p_two_halves;
      $rose(spindle_rate_ok) |-> $past(tach_edge) && $past(half_rev);
   endproperty
   a_two_halves: assert property (p_two_halves)
      else $error("rate ok without two half revolutions");

   property p_gap_expiry;
      gap_t.fire |=> !spindle_rate_ok && !carriage_relay;
   endproperty
   a_gap_expiry: assert property (p_gap_expiry)
      else $error("rate ok survived gap timer expiry");

   property p_relay;
      carriage_relay == spindle_rate_ok;
   endproperty
   a_relay: assert property (p_relay)
      else $error("carriage relay disagrees with rate ok");

   property p_cover_start;
      (state == MOTOR_STOPPED) && !cover_closed && !start_flop
      ##1 thermal_ok
      |=> state != MOTOR_STARTING;
   endproperty
   a_cover_start: assert property (p_cover_start)
      else $error("motor started with cover open");

   property p_solenoid;
      cover_solenoid |-> $past(dc_power_on) && !$past(start_flop) &&
                         !$past(tach_seen);
   endproperty
   a_solenoid: assert property (p_solenoid)
      else $error("cover released while busy or unpowered");

   property p_ops;
      ops_enable |-> spindle_rate_ok;
   endproperty
   a_ops: assert property (p_ops)
      else $error("operations enabled below speed");

   property p_settle;
      $rose(rate_ok_settled) |-> $past(settle_t.fire) && spindle_rate_ok;
   endproperty
   a_settle: assert property (p_settle)
      else $error("settled without delay expiry");

   property p_gap_restart;
      tach_edge |=> gap_t.running && !gap_t.fire;
   endproperty
   a_gap_restart: assert property (p_gap_restart)
      else $error("gap timer not restarted by pulse");

   c_running: cover property (state == MOTOR_RUNNING);
   c_rate_ok: cover property ($rose(spindle_rate_ok));
   c_settled: cover property ($rose(head_load));
   c_tripped: cover property (motor_tripped ##1 state == MOTOR_STOPPED);

endmodule // spindle_speed_interlock

`default_nettype wire

// [tb/spindle_model.sv]
`default_nettype none

// ----------------------------------------------------------------------
// Spindle, pack slugs and tach pickup
// ----------------------------------------------------------------------
module spindle_model (
   input  wire logic mclk,
   input  wire logic rstn,
   input  wire logic run_winding,
   input  wire logic slow,
   output var logic  tach_pulse
);
   timeunit 1ns;
   timeprecision 1ns;

   int phase;

   // Spins only while powered; no coast-down, the harsh case for the gap
   // two pulses per turn
   always @(negedge mclk or negedge rstn) begin
      if (!rstn) begin
         phase      <= 0;
         tach_pulse <= 1'b0;
      end else if (!run_winding) begin
         phase      <= 0;
         tach_pulse <= 1'b0;
      end else begin
         phase      <= (phase >= (slow ? 19 : 9)) ? 0 : phase + 1;
         tach_pulse <= (phase < 2);
      end
   end
endmodule // spindle_model

`default_nettype wire

// [tb/tb_spindle_speed_interlock.sv]
`default_nettype none

module tb_spindle_speed_interlock;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int START  = 20;
   localparam int GAP    = 16;
   localparam int SETTLE = 30;

   logic mclk, rstn, start_req, cover_closed, thermal_ok, thermal_reset;
   logic heads_loaded, tach_pulse, voltage_fault, dc_power_on;
   logic cover_lock_fitted, slow;
   logic start_gated, start_winding, run_winding, motor_tripped, tach_seen;
   logic spindle_rate_ok, rate_ok_settled, carriage_relay, ops_enable;
   logic head_load, cover_solenoid, prev_tach;
   int   failures, samples_checked, edges, n;

   spindle_speed_interlock #(
      .START_CYCLES (START), .GAP_CYCLES (GAP), .SEEN_CYCLES (40),
      .SETTLE_CYCLES(SETTLE), .TIMER_WIDTH(28)
   ) uut (.*);

   spindle_model spindle (.mclk(mclk), .rstn(rstn),
      .run_winding(run_winding), .slow(slow), .tach_pulse(tach_pulse));

   // --------------------------------------------------------------------
   // Clock, edge counter, watchdog
   // --------------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      prev_tach <= tach_pulse;
      if (tach_pulse && !prev_tach)
         edges <= edges + 1;
   end

   // Whole run is a few hundred cycles; this is generous
   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      stop_test();
   end

   // --------------------------------------------------------------------
   // Shared tasks
   // --------------------------------------------------------------------
   task automatic check(input logic got, input logic exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: %s got %b", $time, m, got);
      end
   endtask

   task automatic wait_lvl(ref logic s, input logic v, input int lim);
      n = 0;
      while (s !== v && n < lim) begin
         @(negedge mclk);
         n++;
      end
      check(s, v, "level not reached in time");
   endtask

   task automatic cycles(input int k);
      repeat (k) @(negedge mclk);
   endtask

   task automatic stop_test();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // --------------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------------
   initial begin
      {rstn, start_req, cover_closed, thermal_reset, heads_loaded} = '0;
      {voltage_fault, slow, prev_tach} = '0;
      {thermal_ok, dc_power_on, cover_lock_fitted} = 3'b111;
      failures = 0;
      samples_checked = 0;
      edges = 0;
      cycles(4);
      rstn = 1'b1;
      check(run_winding | spindle_rate_ok | head_load, 1'b0, "reset");
      // Start pressed with the cover open must do nothing
      start_req = 1'b1;
      cycles(6);
      check(start_gated | run_winding | start_winding, 1'b0,
            "cover open");
      cover_closed = 1'b1;
      cycles(2);
      check(start_winding & run_winding, 1'b1, "both windings");
      check(ops_enable | carriage_relay, 1'b0, "ops before speed");
      // Count start winding time; relay and ops follow speed throughout
      n = 0;
      while (start_winding === 1'b1 && n < 40) begin
         check(carriage_relay, spindle_rate_ok, "relay");
         check(ops_enable, spindle_rate_ok, "ops enable");
         if (spindle_rate_ok === 1'b1 && edges < 3)
            check(1'b0, 1'b1, "speed before one turn");
         cycles(1);
         n++;
      end
      check(n == START + 1, 1'b1, "start winding time");
      check(run_winding, 1'b1, "run winding stays");
      wait_lvl(spindle_rate_ok, 1'b1, 20);
      // Settle delay, then head load gated by voltage fault
      n = 0;
      while (rate_ok_settled !== 1'b1 && n < SETTLE + 10) begin
         check(head_load, 1'b0, "early load");
         cycles(1);
         n++;
      end
      check(n >= SETTLE && n <= SETTLE + 4, 1'b1, "settle time");
      check(head_load, 1'b1, "head load");
      voltage_fault = 1'b1;
      cycles(1);
      check(head_load, 1'b0, "load with fault");
      voltage_fault = 1'b0;
      heads_loaded = 1'b1;
      check(cover_solenoid, 1'b0, "solenoid spinning");
      // Half speed: the gap timer must expire
      slow = 1'b1;
      wait_lvl(spindle_rate_ok, 1'b0, GAP + 24);
      // Settled drops one edge after rate ok
      cycles(1);
      check(carriage_relay | ops_enable | rate_ok_settled, 1'b0,
            "slow");
      slow = 1'b0;
      wait_lvl(spindle_rate_ok, 1'b1, 40);
      check(carriage_relay, 1'b1, "relay again");
      // Thermal trip, no restart until manual reset
      thermal_ok = 1'b0;
      cycles(2);
      check(motor_tripped, 1'b1, "tripped");
      check(run_winding | start_winding, 1'b0, "trip windings");
      thermal_ok = 1'b1;
      heads_loaded = 1'b0;
      // Gap timer needs its full span after the last pulse
      cycles(GAP + 4);
      check(run_winding | spindle_rate_ok, 1'b0, "no restart");
      thermal_reset = 1'b1;
      cycles(1);
      thermal_reset = 1'b0;
      wait_lvl(run_winding, 1'b1, 6);
      // Normal stop, then the cover may be released
      start_req = 1'b0;
      wait_lvl(run_winding, 1'b0, 6);
      check(cover_solenoid, 1'b0, "solenoid while seen");
      wait_lvl(cover_solenoid, 1'b1, 60);
      check(tach_seen | start_gated, 1'b0, "release cause");
      dc_power_on = 1'b0;
      cycles(2);
      check(cover_solenoid, 1'b0, "no power");
      dc_power_on = 1'b1;
      cycles(2);
      check(cover_solenoid, 1'b1, "power back");
      cover_lock_fitted = 1'b0;
      cycles(2);
      check(cover_solenoid, 1'b0, "not fitted");
      cover_lock_fitted = 1'b1;
      cycles(2);
      check(cover_solenoid, 1'b1, "fitted again");
      start_req = 1'b1;
      cycles(2);
      check(cover_solenoid, 1'b0, "start locks");
      stop_test();
   end
endmodule // tb_spindle_speed_interlock

`default_nettype wire
